// ### logic/ipc_params.svh
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IPC_IDX_PRIO0 5'h00
`define IPC_IDX_PRIO1 5'h01
`define IPC_IDX_PRIO2 5'h02
`define IPC_IDX_PEND0 5'h11
`define IPC_IDX_PEND1 5'h12
`define IPC_IDX_PEND2 5'h13
`define IPC_IDX_PEND3 5'h14
`define IPC_IDX_PEND4 5'h15
`define IPC_IDX_PEND5 5'h16
`define IPC_IDX_CTRL 5'h1D

// ****************************************
// Writable bit masks, reset values and the fixed PEND5 read value
// ****************************************
`define IPC_MASK_PRIO0 16'h3C00
`define IPC_MASK_PRIO1 16'h003F
`define IPC_MASK_PRIO2 16'hFFCF
`define IPC_RST_PRIO 16'h0000
`define IPC_CTRL_MASK 16'h0001
`define IPC_PEND5_FILL 16'hFFFE

// ****************************************
// Field positions (low bit of each field; level fields are 2 bits wide)
// ****************************************
`define IPC_POS_BKPT 12
`define IPC_POS_STEP 10
`define IPC_POS_DRX 4
`define IPC_POS_DTX 2
`define IPC_POS_TRACE 0
`define IPC_POS_FBE 14
`define IPC_POS_FCC 12
`define IPC_POS_FERR 10
`define IPC_POS_LOCK 8
`define IPC_POS_LVD 6
`define IPC_POS_EXTB 2
`define IPC_POS_EXTA 0
`define IPC_POS_DIS 0
`define IPC_POS_PEND 1

// ****************************************
// Source counts and encodings
// ****************************************
`define IPC_NSRC 12
`define IPC_NDBG 5
`define IPC_LVL_OFF 2'h0
`define IPC_NO_SRC 4'hF

`endif

// ### logic/ipc_pkg.sv
package ipc_pkg;
   // Decoded level handed to the arbiter
   typedef struct packed {
      logic valid;
      logic [1:0] level;
   } ipc_level_s;
   // Request toward the core
   typedef struct packed {
      logic req;
      logic [1:0] level;
      logic [3:0] source;
   } ipc_core_req_s;
   // Bus cycle phase
   typedef enum logic {IPC_IDLE, IPC_ACKED} ipc_bus_e;
endpackage

// ### logic/ipc_level_decode.sv
`include "ipc_params.svh"

// Turns one 2-bit level field into enable plus priority level
module ipc_level_decode #(
   parameter bit DEBUG_MAP = 1'b1
) (
   // Field in
   input wire logic [1:0] field_i,
   // Decoded level out
   output ipc_pkg::ipc_level_s level_o
);
   // Debug map: 01..11 -> 1..3, others: 01..11 -> 0..2, 00 -> off
   always_comb
   begin
      level_o.valid = (field_i != `IPC_LVL_OFF);
      if (DEBUG_MAP)
         level_o.level = field_i;
      else
         level_o.level = field_i - 2'h1;
   end
endmodule

// ### logic/ipc_unit.sv
// Register access over Wishbone was left to the implementer.
`include "ipc_params.svh"

module ipc_unit (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [6:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Peripheral request lines, order: bkpt,step,drx,dtx,trace,fbe,fcc,ferr,lock,lvd,extb,exta
   input wire logic [11:0] src_req_i,
   // Core interrupt request
   output ipc_pkg::ipc_core_req_s core_req_o
);
   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] priority_reg_0;
   logic [15:0] priority_reg_1;
   logic [15:0] priority_reg_2;
   logic [15:0] interrupt_control;
   ipc_pkg::ipc_bus_e bus_state;
   logic [1:0] fields [`IPC_NSRC];
   ipc_pkg::ipc_level_s lvl [`IPC_NSRC];
   logic [11:0] pend;
   logic [11:0] masked;
   logic [15:0] next_rdata;
   logic [4:0] idx;
   logic access;
   logic bus_write;
   logic [15:0] wmask;
   ipc_pkg::ipc_core_req_s next_req;

   assign idx = wb_adr_i[6:2];
   assign access = wb_cyc_i && wb_stb_i && (bus_state == ipc_pkg::IPC_IDLE);
   assign bus_write = access && wb_we_i;
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // ****************************************
   // Bus handshake
   // ****************************************
   // Ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bus_state <= ipc_pkg::IPC_IDLE;
      else if (access)
         bus_state <= ipc_pkg::IPC_ACKED;
      else
         bus_state <= ipc_pkg::IPC_IDLE;
   end
   assign wb_ack_o = (bus_state == ipc_pkg::IPC_ACKED);

   // ****************************************
   // Priority registers
   // ****************************************
   // reset to disabled
   // masked writes keep reserved bits zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         priority_reg_0 <= `IPC_RST_PRIO;
         priority_reg_1 <= `IPC_RST_PRIO;
         priority_reg_2 <= `IPC_RST_PRIO;
      end
      else if (bus_write)
      begin
         if (idx == `IPC_IDX_PRIO0)
            priority_reg_0 <= (priority_reg_0 & ~(wmask & `IPC_MASK_PRIO0))
               | (wb_dat_i[15:0] & wmask & `IPC_MASK_PRIO0);
         if (idx == `IPC_IDX_PRIO1)
            priority_reg_1 <= (priority_reg_1 & ~(wmask & `IPC_MASK_PRIO1))
               | (wb_dat_i[15:0] & wmask & `IPC_MASK_PRIO1);
         if (idx == `IPC_IDX_PRIO2)
            priority_reg_2 <= (priority_reg_2 & ~(wmask & `IPC_MASK_PRIO2))
               | (wb_dat_i[15:0] & wmask & `IPC_MASK_PRIO2);
      end
   end

   // Global disable bit in the control word
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         interrupt_control <= 16'h0000;
      else if (bus_write && idx == `IPC_IDX_CTRL && wb_sel_i[0])
         interrupt_control <= wb_dat_i[15:0] & `IPC_CTRL_MASK;
   end

   // ****************************************
   // Level decode
   // ****************************************
   // Field extraction per source
   always_comb
   begin
      fields[0] = priority_reg_0[`IPC_POS_BKPT +: 2];
      fields[1] = priority_reg_0[`IPC_POS_STEP +: 2];
      fields[2] = priority_reg_1[`IPC_POS_DRX +: 2];
      fields[3] = priority_reg_1[`IPC_POS_DTX +: 2];
      fields[4] = priority_reg_1[`IPC_POS_TRACE +: 2];
      fields[5] = priority_reg_2[`IPC_POS_FBE +: 2];
      fields[6] = priority_reg_2[`IPC_POS_FCC +: 2];
      fields[7] = priority_reg_2[`IPC_POS_FERR +: 2];
      fields[8] = priority_reg_2[`IPC_POS_LOCK +: 2];
      fields[9] = priority_reg_2[`IPC_POS_LVD +: 2];
      fields[10] = priority_reg_2[`IPC_POS_EXTB +: 2];
      fields[11] = priority_reg_2[`IPC_POS_EXTA +: 2];
   end

   for (genvar g = 0; g < `IPC_NSRC; g++)
   begin : g_dec
      ipc_level_decode #(.DEBUG_MAP(g < `IPC_NDBG)) u_dec (
         .field_i(fields[g]),
         .level_o(lvl[g])
      );
   end

   // ****************************************
   // Pending and arbitration
   // ****************************************
   // pending flags follow request lines of all sources, enable is applied in masked
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pend <= 12'h000;
      else
         pend <= src_req_i;
   end

   always_comb
   begin
      for (int i = 0; i < `IPC_NSRC; i++)
         masked[i] = pend[i] && lvl[i].valid;
   end

   // highest level wins, lowest index breaks ties
   always_comb
   begin
      next_req.req = 1'b0;
      next_req.level = 2'h0;
      next_req.source = `IPC_NO_SRC;
      for (int i = `IPC_NSRC - 1; i >= 0; i--)
      begin
         if (masked[i] && (!next_req.req || lvl[i].level >= next_req.level))
         begin
            next_req.req = 1'b1;
            next_req.level = lvl[i].level;
            next_req.source = 4'(i);
         end
      end
      if (interrupt_control[`IPC_POS_DIS])
         next_req = '{req: 1'b0, level: 2'h0, source: `IPC_NO_SRC};
   end

   // Registered request toward the core
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         core_req_o <= '{req: 1'b0, level: 2'h0, source: `IPC_NO_SRC};
      else
         core_req_o <= next_req;
   end

   // ****************************************
   // Read data
   // ****************************************
   // read mux, unmapped reads zero
   always_comb
   begin
      case (idx)
         `IPC_IDX_PRIO0: next_rdata = priority_reg_0;
         `IPC_IDX_PRIO1: next_rdata = priority_reg_1;
         `IPC_IDX_PRIO2: next_rdata = priority_reg_2;
         `IPC_IDX_PEND0: next_rdata = {3'h0, masked, 1'b1};
         `IPC_IDX_PEND1, `IPC_IDX_PEND2, `IPC_IDX_PEND3, `IPC_IDX_PEND4:
            next_rdata = 16'h0000;
         `IPC_IDX_PEND5: next_rdata = `IPC_PEND5_FILL;
         `IPC_IDX_CTRL: next_rdata = interrupt_control;
         default: next_rdata = 16'h0000;
      endcase
   end

   // Read data captured with the acknowledge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (access && !wb_we_i)
         wb_dat_o <= {16'h0000, next_rdata};
   end

   // ****************************************
   // Assertions
   // ****************************************
   // reserved reg0 bits
   AST_RSV0: assert property (@(posedge clk_i) disable iff (rst_i)
      (priority_reg_0 & ~`IPC_MASK_PRIO0) == 16'h0000)
      else $error("reserved bits set in reg0");

   AST_RSV1: assert property (@(posedge clk_i) disable iff (rst_i)
      (priority_reg_1 & ~`IPC_MASK_PRIO1) == 16'h0000)
      else $error("reserved bits set in reg1");

   AST_RSV2: assert property (@(posedge clk_i) disable iff (rst_i)
      (priority_reg_2 & ~`IPC_MASK_PRIO2) == 16'h0000)
      else $error("reserved bits set in reg2");

   AST_RST: assert property (@(posedge clk_i) $past(rst_i) |->
      priority_reg_1 == `IPC_RST_PRIO && !core_req_o.req)
      else $error("not cleared by reset");

   AST_RST_ALL: assert property (@(posedge clk_i) $past(rst_i) |->
      priority_reg_0 == `IPC_RST_PRIO && priority_reg_2 == `IPC_RST_PRIO)
      else $error("level fields not cleared by reset");

   AST_DBG: assert property (@(posedge clk_i) disable iff (rst_i) lvl[0].valid |->
      lvl[0].level == priority_reg_0[`IPC_POS_BKPT +: 2])
      else $error("debug level map wrong");

   AST_DBG_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      priority_reg_0[`IPC_POS_BKPT +: 2] == `IPC_LVL_OFF |-> !lvl[0].valid)
      else $error("disabled debug field decoded as enabled");

   AST_TRACE: assert property (@(posedge clk_i) disable iff (rst_i)
      priority_reg_1[`IPC_POS_TRACE +: 2] == 2'h3 |-> lvl[4].valid && lvl[4].level == 2'h3)
      else $error("trace level map wrong");

   AST_PER: assert property (@(posedge clk_i) disable iff (rst_i)
      priority_reg_2[`IPC_POS_EXTA +: 2] == 2'h3 |-> lvl[11].level == 2'h2)
      else $error("peripheral level map wrong");

   AST_PER_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      priority_reg_2[`IPC_POS_FBE +: 2] == 2'h1 |-> lvl[5].valid && lvl[5].level == 2'h0)
      else $error("flash buffer level map wrong");

   AST_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 (core_req_o.req && core_req_o.source == 4'h5) |->
      $past(priority_reg_2[`IPC_POS_FBE +: 2]) != `IPC_LVL_OFF)
      else $error("disabled source forwarded");

   AST_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_write && idx == `IPC_IDX_PRIO1 && wb_sel_i[0] |=>
      (priority_reg_1 & `IPC_MASK_PRIO1) == ($past(wb_dat_i[15:0]) & `IPC_MASK_PRIO1))
      else $error("write to reg1 lost");

   AST_WR_BKPT: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_write && idx == `IPC_IDX_PRIO0 && wb_sel_i[1] |=>
      priority_reg_0[`IPC_POS_BKPT +: 2] == $past(wb_dat_i[`IPC_POS_BKPT +: 2]))
      else $error("write to breakpoint field lost");

   AST_WR_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_write && idx == `IPC_IDX_PRIO0 && wb_sel_i[1] |=>
      priority_reg_0[`IPC_POS_STEP +: 2] == $past(wb_dat_i[`IPC_POS_STEP +: 2]))
      else $error("write to step counter field lost");

   AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
      access |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing wrong");

   AST_FWD: assert property (@(posedge clk_i) disable iff (rst_i)
      (|masked && !interrupt_control[`IPC_POS_DIS]) |=> core_req_o.req)
      else $error("pending source not forwarded");

   AST_DIS: assert property (@(posedge clk_i) disable iff (rst_i)
      interrupt_control[`IPC_POS_DIS] |=> !core_req_o.req)
      else $error("request forwarded while disabled");

   AST_PEND: assert property (@(posedge clk_i) disable iff (rst_i)
      access && !wb_we_i && idx == `IPC_IDX_PEND0 |=>
      wb_dat_o[`IPC_POS_PEND +: `IPC_NSRC] == $past(masked))
      else $error("pending word read wrong");
endmodule

// ### tb/ipc_partner.sv
// Peripheral request lines seen by the unit
module ipc_partner (
   // Clock
   input wire logic clk_i,
   // Requests the bench asks for
   input wire logic [11:0] want_i,
   // Level lines toward the unit
   output logic [11:0] src_req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Peripherals move their lines only on clock edges
   always @(posedge clk_i)
   begin
      src_req_o <= want_i;
   end
endmodule

// ### tb/tb.sv
// Compare and count
`define CHK(nm, ex, gt) \
   begin \
      checks_done++; \
      if ((gt) !== (ex)) \
      begin \
         errors++; \
         $display("mismatch %s exp %h got %h", nm, ex, gt); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i;
   logic rst_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [6:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [3:0] byte_sel;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [11:0] want;
   logic [11:0] src_req;
   ipc_pkg::ipc_core_req_s core_req_o;
   int errors = 0;
   int checks_done = 0;
   // Unit and peripheral model
   ipc_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_req_i(src_req), .core_req_o(core_req_o));
   ipc_partner peri (.clk_i(clk_i), .want_i(want), .src_req_o(src_req));
   // 50 ns clock
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One classic bus cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [6:0] adr, input logic [15:0] wd,
      output logic [31:0] rd);
      int n = 0;
      rd = 32'h00000000;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= byte_sel;
      wb_dat_i <= {16'h0000, wd};
      // Ack and read data are taken at the same rising edge
      do
      begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o === 1'b1)
      begin
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
      else
      begin
         errors++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [6:0] adr, input logic [15:0] wd);
      logic [31:0] rd;
      wb(1'b1, adr, wd, rd);
   endtask
   task automatic rdc(input string nm, input logic [6:0] adr, input logic [31:0] ex);
      logic [31:0] rd;
      wb(1'b0, adr, 16'h0000, rd);
      `CHK(nm, ex, rd)
   endtask
   // Set request lines and let them reach the core output
   task automatic raise(input logic [11:0] w);
      want <= w;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic scen_reset_and_masks;
      rdc("reg0 reset", 7'h00, 32'h00000000);
      rdc("reg1 reset", 7'h04, 32'h00000000);
      rdc("reg2 reset", 7'h08, 32'h00000000);
      wr(7'h00, 16'hFFFF);
      wr(7'h04, 16'hFFFF);
      wr(7'h08, 16'hFFFF);
      wr(7'h0C, 16'hFFFF);
      rdc("reg0 mask", 7'h00, 32'h00003C00);
      rdc("reg1 mask", 7'h04, 32'h0000003F);
      rdc("reg2 mask", 7'h08, 32'h0000FFCF);
      rdc("unmapped", 7'h0C, 32'h00000000);
      wr(7'h00, 16'h0000);
      wr(7'h04, 16'h0000);
      wr(7'h08, 16'h0000);
   endtask
   // Every field code on one debug and one flash source
   task automatic scen_decode;
      for (int f = 0; f < 4; f++)
      begin
         wr(7'h00, 16'(f << 12));
         raise(12'h001);
         `CHK("dbg req", (f != 0), core_req_o.req)
         if (f != 0)
            `CHK("dbg lvl", 6'(f << 4), core_req_o[5:0])
         wr(7'h00, 16'h0000);
         wr(7'h08, 16'(f << 14));
         raise(12'h020);
         `CHK("fl req", (f != 0), core_req_o.req)
         if (f != 0)
            `CHK("fl lvl", 6'(((f - 1) << 4) | 5), core_req_o[5:0])
         wr(7'h08, 16'h0000);
         raise(12'h000);
      end
   endtask
   // Highest level wins, pend0 word follows enabled requests
   task automatic scen_priority;
      wr(7'h00, 16'h1000);
      wr(7'h08, 16'h0003);
      raise(12'hC21);
      `CHK("win exta", 7'h6B, core_req_o)
      rdc("pend0", 7'h44, 32'h00001003);
      rdc("pend5", 7'h58, 32'h0000FFFE);
      wr(7'h00, 16'h3000);
      raise(12'hC21);
      `CHK("win bkpt", 7'h70, core_req_o)
      raise(12'h000);
      `CHK("idle", 1'b0, core_req_o.req)
   endtask
   // Global disable, low byte write and a reset in mid-run
   task automatic scen_ctrl_and_reset;
      wr(7'h08, 16'h0002);
      raise(12'h800);
      `CHK("ext a on", 7'h5B, core_req_o)
      wr(7'h74, 16'hFFFF);
      rdc("ctrl", 7'h74, 32'h00000001);
      raise(12'h800);
      `CHK("disabled", 7'h0F, core_req_o)
      wr(7'h74, 16'h0000);
      raise(12'h800);
      `CHK("enabled", 7'h5B, core_req_o)
      byte_sel = 4'h1;
      wr(7'h08, 16'hFFFF);
      byte_sel = 4'h3;
      rdc("reg2 low byte", 7'h08, 32'h000000CF);
      raise(12'h000);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("reg0 rerun", 7'h00, 32'h00000000);
      rdc("reg2 rerun", 7'h08, 32'h00000000);
      raise(12'h800);
      `CHK("silent", 1'b0, core_req_o.req)
      raise(12'h000);
   endtask
   initial
   begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 7'h00;
      wb_dat_i = 32'h00000000;
      want = 12'h000;
      wb_sel_i = 4'h3;
      byte_sel = 4'h3;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      scen_reset_and_masks();
      scen_decode();
      scen_priority();
      scen_ctrl_and_reset();
      finish_test();
   end
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk_i);
      errors++;
      finish_test();
   end
endmodule
